// ==== verilog/flash_host_pkg.sv ====
package flash_host_pkg;
   localparam int CLK_MHZ = 125;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int SECTOR_BYTES = 128;
   localparam int SECTOR_LSB = 7;
   localparam int CMD_ADDR_W = 15;
   // bus and program timing, ns except T_BLC_US in us and T_WC_MS in ms
   localparam int T_WP_NS = 200;
   localparam int T_WPH_NS = 200;
   localparam int T_AS_NS = 10;
   localparam int T_AH_NS = 100;
   localparam int T_ACC_NS = 120;
   localparam int T_OEHP_NS = 150;
   localparam int T_BLC_US = 150;
   localparam int T_WC_MS = 20;
   // least times and access time round up, access with 2 cycles added; us and ms times scale exactly
   localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
   localparam int WPH_CYC = (T_WPH_NS * CLK_MHZ + 999) / 1000;
   localparam int AS_CYC = (T_AS_NS * CLK_MHZ + 999) / 1000;
   localparam int AH_CYC = (T_AH_NS * CLK_MHZ + 999) / 1000;
   localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000 + 2;
   localparam int OEHP_CYC = (T_OEHP_NS * CLK_MHZ + 999) / 1000;
   localparam int BLC_CYC = T_BLC_US * CLK_MHZ;
   localparam int WC_CYC = T_WC_MS * 1000 * CLK_MHZ;
   // command sequence words
   localparam logic [14:0] CMD_ADDR_A = 15'h5555;
   localparam logic [14:0] CMD_ADDR_B = 15'h2AAA;
   localparam logic [7:0] CMD_D_AA = 8'hAA;
   localparam logic [7:0] CMD_D_55 = 8'h55;
   localparam logic [7:0] CMD_D_80 = 8'h80;
   localparam logic [7:0] CMD_D_PROG = 8'hA0;
   localparam logic [7:0] CMD_D_ID_ENTER = 8'h90;
   localparam logic [7:0] CMD_D_ID_EXIT = 8'hF0;
   localparam logic [7:0] CMD_D_LOCK = 8'h40;
   localparam logic [14:0] LOCK_ADDR_LOW = 15'h0000;
   localparam logic [14:0] LOCK_ADDR_HIGH = 15'h7FFF;
   localparam logic [16:0] ID_LOCK_LOW_ADDR = 17'h0_0002;
   localparam logic [16:0] ID_LOCK_HIGH_ADDR = 17'h1_FFF2;
   localparam logic [7:0] LOCK_FREE_VAL = 8'hFE;
   localparam int TOGGLE_BIT = 6;
   typedef enum logic [2:0] {
      OP_READ, OP_PROGRAM, OP_ID_ENTER, OP_ID_EXIT, OP_LOCK_LOW, OP_LOCK_HIGH, OP_POLL
   } op_t;
endpackage

// ==== verilog/flash_bus_cycle.sv ====
`timescale 1ns/1ns
// one write or read cycle on the flash pins
module flash_bus_cycle
   import flash_host_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic clk_en_in,
   input wire logic start_in,
   input wire logic write_in,
   input wire logic [flash_host_pkg::ADDR_W-1:0] addr_in,
   input wire logic [flash_host_pkg::DATA_W-1:0] wdata_in,
   input wire logic [flash_host_pkg::DATA_W-1:0] pin_data_sync_in,
   output logic busy_out,
   output logic done_out,
   output logic [flash_host_pkg::DATA_W-1:0] rdata_out,
   output logic [flash_host_pkg::ADDR_W-1:0] pin_addr_out,
   output logic [flash_host_pkg::DATA_W-1:0] pin_data_out,
   output logic pin_data_oe_n_out,
   output logic chip_sel_n_out,
   output logic out_en_n_out,
   output logic write_n_out
);
   typedef enum logic [2:0] {C_IDLE, C_SETUP, C_PULSE, C_HOLD, C_GAP} cyc_t;
   cyc_t state_reg;
   logic wr_reg;
   logic [15:0] cnt_reg;
   localparam int RD_CYC = ACC_CYC + 2;

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         state_reg <= C_IDLE;
         cnt_reg <= 16'h0000;
         wr_reg <= 1'b0;
         busy_out <= 1'b0;
         done_out <= 1'b0;
         rdata_out <= 8'h00;
         pin_addr_out <= 17'h0_0000;
         pin_data_out <= 8'h00;
         pin_data_oe_n_out <= 1'b1;
         chip_sel_n_out <= 1'b1;
         out_en_n_out <= 1'b1;
         write_n_out <= 1'b1;
      end else if (clk_en_in) begin
         done_out <= 1'b0;
         case (state_reg)
            C_IDLE: begin
               if (start_in) begin
                  busy_out <= 1'b1;
                  wr_reg <= write_in;
                  pin_addr_out <= addr_in;
                  pin_data_out <= wdata_in;
                  pin_data_oe_n_out <= !write_in;
                  chip_sel_n_out <= 1'b0;
                  // output enable stays high for writes
                  out_en_n_out <= write_in;
                  cnt_reg <= 16'(AS_CYC);
                  state_reg <= C_SETUP;
               end
            end
            C_SETUP: begin
               if (cnt_reg <= 16'h0001) begin
                  write_n_out <= !wr_reg;
                  cnt_reg <= wr_reg ? 16'(WP_CYC) : 16'(RD_CYC);
                  state_reg <= C_PULSE;
               end else begin
                  cnt_reg <= cnt_reg - 16'h0001;
               end
            end
            C_PULSE: begin
               if (cnt_reg <= 16'h0001) begin
                  write_n_out <= 1'b1;
                  out_en_n_out <= 1'b1;
                  rdata_out <= pin_data_sync_in;
                  cnt_reg <= 16'(AH_CYC);
                  state_reg <= C_HOLD;
               end else begin
                  cnt_reg <= cnt_reg - 16'h0001;
               end
            end
            C_HOLD: begin
               if (cnt_reg <= 16'h0001) begin
                  chip_sel_n_out <= 1'b1;
                  pin_data_oe_n_out <= 1'b1;
                  // covers both write-high and output-enable-high gaps
                  cnt_reg <= 16'(WPH_CYC > OEHP_CYC ? WPH_CYC : OEHP_CYC);
                  state_reg <= C_GAP;
               end else begin
                  cnt_reg <= cnt_reg - 16'h0001;
               end
            end
            C_GAP: begin
               if (cnt_reg <= 16'h0001) begin
                  busy_out <= 1'b0;
                  done_out <= 1'b1;
                  state_reg <= C_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 16'h0001;
               end
            end
            default: state_reg <= C_IDLE;
         endcase
      end
   end

   a_oe_high_write: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (!chip_sel_n_out && !write_n_out) |-> out_en_n_out)
      else $error("output enable low during write strobe");
   a_wp_width: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (clk_en_in && $fell(write_n_out)) |-> !write_n_out [*2])
      else $error("write pulse too short");
endmodule

// ==== verilog/flash_prog_host.sv ====
`timescale 1ns/1ns
module flash_prog_host
   import flash_host_pkg::*;
#(
   parameter int BLC_CYCLES = BLC_CYC,
   parameter int WC_CYCLES = WC_CYC
)(
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic clk_en_in,
   input wire logic req_valid_in,
   input wire flash_host_pkg::op_t req_op_in,
   input wire logic [flash_host_pkg::ADDR_W-1:0] req_addr_in,
   input wire logic [flash_host_pkg::DATA_W-1:0] req_wdata_in,
   input wire logic pin_data_in,
   input wire logic [flash_host_pkg::DATA_W-1:0] flash_data_in,
   output logic req_ready_out,
   output logic data_req_out,
   output logic resp_valid_out,
   output logic [flash_host_pkg::DATA_W-1:0] resp_data_out,
   output logic timeout_err_out,
   output logic [flash_host_pkg::ADDR_W-1:0] flash_addr_out,
   output logic [flash_host_pkg::DATA_W-1:0] flash_data_out,
   output logic flash_data_oe_n_out,
   output logic chip_sel_n_out,
   output logic out_en_n_out,
   output logic write_n_out
);
   import flash_host_pkg::*;
   typedef enum logic [3:0] {
      S_IDLE, S_CMD, S_LOAD_WAIT, S_LOAD, S_POLL_A, S_POLL_B, S_READ, S_RESP
   } st_t;
   st_t state_reg;
   op_t op_reg;
   logic [1:0] cmd_idx_reg;
   logic [7:0] load_cnt_reg;
   logic [31:0] timer_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] prev_reg;
   logic [DATA_W-1:0] sync1_reg;
   logic [DATA_W-1:0] sync2_reg;
   logic cyc_start;
   logic cyc_write;
   logic [ADDR_W-1:0] cyc_addr;
   logic [DATA_W-1:0] cyc_data;
   logic cyc_busy;
   logic cyc_done;
   logic [DATA_W-1:0] cyc_rdata;
   logic [14:0] cmd_a;
   logic [7:0] cmd_d;
   logic [7:0] op_byte;
   logic [7:0] boot_lock_reg;

   // data pins come from outside the clock domain
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         sync1_reg <= 8'h00;
         sync2_reg <= 8'h00;
      end else if (clk_en_in) begin
         sync1_reg <= flash_data_in;
         sync2_reg <= sync1_reg;
      end
   end

   always_comb begin
      case (op_reg)
         OP_PROGRAM: op_byte = CMD_D_PROG;
         OP_ID_ENTER: op_byte = CMD_D_ID_ENTER;
         OP_ID_EXIT: op_byte = CMD_D_ID_EXIT;
         default: op_byte = CMD_D_80;
      endcase
   end

   // unlock prefix then command; lockout uses a six-write variant
   always_comb begin
      cmd_a = CMD_ADDR_A;
      cmd_d = CMD_D_AA;
      case (cmd_idx_reg)
         2'h1: begin
            cmd_a = CMD_ADDR_B;
            cmd_d = CMD_D_55;
         end
         2'h2: cmd_d = op_byte;
         default: ;
      endcase
      if ((op_reg == OP_LOCK_LOW || op_reg == OP_LOCK_HIGH) && boot_lock_reg[0] &&
          cmd_idx_reg == 2'h2) begin
         // final write of lockout variant picks the block
         cmd_a = (op_reg == OP_LOCK_LOW) ? LOCK_ADDR_LOW : LOCK_ADDR_HIGH;
         cmd_d = CMD_D_LOCK;
      end
   end

   always_comb begin
      cyc_start = 1'b0;
      cyc_write = 1'b1;
      cyc_addr = {2'b00, cmd_a};
      cyc_data = cmd_d;
      case (state_reg)
         S_CMD: cyc_start = !cyc_busy && !cyc_done;
         S_LOAD: begin
            cyc_start = !cyc_busy && !cyc_done;
            // sector bits from the program request address, offset from current load
            cyc_addr = {addr_reg[ADDR_W-1:SECTOR_LSB], req_addr_in[SECTOR_LSB-1:0]};
            cyc_data = req_wdata_in;
         end
         S_POLL_A, S_POLL_B, S_READ: begin
            cyc_start = !cyc_busy && !cyc_done;
            cyc_write = 1'b0;
            cyc_addr = addr_reg;
         end
         default: ;
      endcase
   end

   flash_bus_cycle u_cycle (
      .sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .clk_en_in(clk_en_in),
      .start_in(cyc_start),
      .write_in(cyc_write),
      .addr_in(cyc_addr),
      .wdata_in(cyc_data),
      .pin_data_sync_in(sync2_reg),
      .busy_out(cyc_busy),
      .done_out(cyc_done),
      .rdata_out(cyc_rdata),
      .pin_addr_out(flash_addr_out),
      .pin_data_out(flash_data_out),
      .pin_data_oe_n_out(flash_data_oe_n_out),
      .chip_sel_n_out(chip_sel_n_out),
      .out_en_n_out(out_en_n_out),
      .write_n_out(write_n_out)
   );

   // boot_lock_reg[0] marks lockout second phase
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         state_reg <= S_IDLE;
         op_reg <= OP_READ;
         cmd_idx_reg <= 2'h0;
         load_cnt_reg <= 8'h00;
         timer_reg <= 32'h0000_0000;
         addr_reg <= 17'h0_0000;
         prev_reg <= 8'h00;
         boot_lock_reg <= 8'h00;
         req_ready_out <= 1'b0;
         data_req_out <= 1'b0;
         resp_valid_out <= 1'b0;
         resp_data_out <= 8'h00;
         timeout_err_out <= 1'b0;
      end else if (clk_en_in) begin
         resp_valid_out <= 1'b0;
         data_req_out <= 1'b0;
         req_ready_out <= (state_reg == S_IDLE) && !req_valid_in;
         case (state_reg)
            S_IDLE: begin
               req_ready_out <= 1'b1;
               if (req_valid_in && req_ready_out) begin
                  req_ready_out <= 1'b0;
                  op_reg <= req_op_in;
                  addr_reg <= req_addr_in;
                  cmd_idx_reg <= 2'h0;
                  boot_lock_reg <= 8'h00;
                  timeout_err_out <= 1'b0;
                  state_reg <= (req_op_in == OP_READ) ? S_READ :
                               (req_op_in == OP_POLL) ? S_POLL_A : S_CMD;
               end
            end
            S_CMD: if (cyc_done) begin
               if (cmd_idx_reg != 2'h2) begin
                  cmd_idx_reg <= cmd_idx_reg + 2'h1;
               end else if ((op_reg == OP_LOCK_LOW || op_reg == OP_LOCK_HIGH) &&
                            !boot_lock_reg[0]) begin
                  boot_lock_reg <= 8'h01;
                  cmd_idx_reg <= 2'h0;
               end else if (op_reg == OP_PROGRAM) begin
                  // protection re-arms per cycle, so unlock precedes every sector
                  load_cnt_reg <= 8'h00;
                  data_req_out <= 1'b1;
                  timer_reg <= 32'(BLC_CYCLES);
                  state_reg <= S_LOAD_WAIT;
               end else begin
                  state_reg <= S_RESP;
               end
            end
            S_LOAD_WAIT: begin
               if (req_valid_in) begin
                  state_reg <= S_LOAD;
               end else if (timer_reg <= 32'h0000_0001) begin
                  // window lapsed: device already programming a partial sector
                  timeout_err_out <= 1'b1;
                  state_reg <= S_POLL_A;
               end else begin
                  timer_reg <= timer_reg - 32'h0000_0001;
               end
            end
            S_LOAD: if (cyc_done) begin
               load_cnt_reg <= load_cnt_reg + 8'h01;
               timer_reg <= 32'(BLC_CYCLES);
               if (load_cnt_reg == 8'(SECTOR_BYTES - 1)) begin
                  // all bytes loaded; unloaded would read indeterminate
                  state_reg <= S_POLL_A;
               end else begin
                  data_req_out <= 1'b1;
                  state_reg <= S_LOAD_WAIT;
               end
            end
            S_POLL_A: if (cyc_done) begin
               prev_reg <= cyc_rdata;
               timer_reg <= 32'(WC_CYCLES);
               state_reg <= S_POLL_B;
            end
            S_POLL_B: if (cyc_done) begin
               prev_reg <= cyc_rdata;
               // compare only change of the bit, never its value
               if (cyc_rdata[TOGGLE_BIT] == prev_reg[TOGGLE_BIT]) begin
                  resp_data_out <= cyc_rdata;
                  state_reg <= S_RESP;
               end else if (timer_reg <= 32'h0000_0001) begin
                  timeout_err_out <= 1'b1;
                  state_reg <= S_RESP;
               end
            end else if (timer_reg > 32'h0000_0001) begin
               timer_reg <= timer_reg - 32'h0000_0001;
            end
            S_READ: if (cyc_done) begin
               // id reads: 0/1 codes, lock bytes FE/FF at lock addresses
               resp_data_out <= cyc_rdata;
               state_reg <= S_RESP;
            end
            S_RESP: begin
               resp_valid_out <= 1'b1;
               state_reg <= S_IDLE;
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   a_load_full: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (state_reg == S_LOAD && cyc_done && load_cnt_reg != 8'(SECTOR_BYTES - 1))
      |=> state_reg == S_LOAD_WAIT)
      else $error("load sequence ended early");
   a_sector_stable: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (state_reg == S_LOAD && cyc_start)
      |-> cyc_addr[ADDR_W-1:SECTOR_LSB] == addr_reg[ADDR_W-1:SECTOR_LSB])
      else $error("sector address changed during load");
   a_poll_addr: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (state_reg == S_POLL_B && cyc_start) |-> cyc_addr == addr_reg)
      else $error("poll address changed");
   a_cmd_width: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (state_reg == S_CMD && cyc_start) |-> cyc_addr[16:15] == 2'b00)
      else $error("command address above 15 bits");
   a_load_window: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (state_reg == S_LOAD_WAIT) |-> timer_reg <= 32'(BLC_CYCLES))
      else $error("byte-load window overrun");
   a_resp_pulse: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      resp_valid_out |=> !resp_valid_out)
      else $error("response held too long");
   a_unlock_first: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (state_reg == S_IDLE && req_valid_in && req_ready_out && req_op_in == OP_PROGRAM)
      |=> state_reg == S_CMD && cmd_idx_reg == 2'h0)
      else $error("program without unlock");
   a_oe_write: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      !write_n_out |-> out_en_n_out)
      else $error("output enable low in write");
endmodule

// ==== tb/flash_dev_model.sv ====
`timescale 1ns/1ns
// behavioural flash part on the far side of the host pins
module flash_dev_model
   import flash_host_pkg::*;
#(
   parameter int BLC_NS = 1600,
   parameter int PROG_NS = 2000,
   parameter logic [7:0] MAKER_ID = 8'h6C, // arbitrary value
   parameter logic [7:0] PART_ID = 8'h93 // arbitrary value
)(
   input wire logic [16:0] addr_in,
   input wire logic [7:0] host_data_in,
   input wire logic cs_n_in,
   input wire logic oe_n_in,
   input wire logic we_n_in,
   output logic [7:0] data_out,
   output int fault_out
);
   logic [7:0] mem [0:131071];
   logic [7:0] lbuf [0:127];
   bit loaded [0:127];
   bit id_mode = 0;
   bit loading = 0;
   bit busy = 0;
   bit lock_lo = 0;
   bit lock_hi = 0;
   bit tog = 0;
   bit poll_set = 0;
   int step = 0;
   int nload = 0;
   time t_evt = 0;
   logic [9:0] sector = '0;
   logic [16:0] poll_addr = '0;
   logic [7:0] rd = 8'h00;
   wire chip_erase_ok = !(lock_lo || lock_hi);
   initial fault_out = 0;
   initial for (int i = 0; i < 131072; i++) mem[i] = i[7:0] ^ i[15:8];
   // off-bus, show the inverse of the last driven byte
   assign data_out = (!cs_n_in && !oe_n_in) ? rd : ~rd;

   task automatic start_prog();
      loading = 0;
      busy = 1;
      poll_set = 0;
      t_evt = $time;
   endtask

   task automatic finish_prog();
      logic [16:0] a;
      busy = 0;
      for (int i = 0; i < 128; i++) begin
         a = {sector, i[6:0]};
         if (!((lock_lo && a < 17'h0_2000) || (lock_hi && a >= 17'h1_E000)))
            mem[a] = loaded[i] ? lbuf[i] : ~mem[a];
      end
   endtask

   task automatic cmd(input logic [14:0] a, input logic [7:0] d);
      case (step)
         0, 3: step = (a == CMD_ADDR_A && d == CMD_D_AA) ? step + 1 : 0;
         1, 4: step = (a == CMD_ADDR_B && d == CMD_D_55) ? step + 1 : 0;
         2: begin
            step = (a == CMD_ADDR_A && d == CMD_D_80) ? 3 : 0;
            if (a == CMD_ADDR_A && d == CMD_D_PROG) begin
               loading = 1;
               nload = 0;
               t_evt = $time;
               foreach (loaded[i]) loaded[i] = 0;
            end
            if (a == CMD_ADDR_A && d == CMD_D_ID_ENTER) id_mode = 1;
            if (a == CMD_ADDR_A && d == CMD_D_ID_EXIT) id_mode = 0;
         end
         5: begin
            step = 0;
            if (d == CMD_D_LOCK && a == LOCK_ADDR_LOW) lock_lo = 1;
            if (d == CMD_D_LOCK && a == LOCK_ADDR_HIGH) lock_hi = 1;
         end
         default: step = 0;
      endcase
   endtask

   always @(negedge we_n_in) if (!cs_n_in && !oe_n_in) fault_out++;

   always @(posedge we_n_in) if (!cs_n_in) begin
      if (loading) begin
         if (nload == 0) sector = addr_in[16:7];
         if (addr_in[16:7] !== sector) fault_out++;
         lbuf[addr_in[6:0]] = host_data_in;
         loaded[addr_in[6:0]] = 1;
         nload++;
         t_evt = $time;
         if (nload == 128) start_prog();
      end else if (!busy) begin
         cmd(addr_in[14:0], host_data_in);
      end
   end

   always #40 begin
      if (loading && $time - t_evt >= BLC_NS) start_prog();
      if (busy && $time - t_evt >= PROG_NS) finish_prog();
   end

   // settle after the strobe so the address update lands first
   always @(negedge oe_n_in or negedge cs_n_in) begin
      #2;
      if (!oe_n_in && !cs_n_in) begin
         if (busy) begin
            if (poll_set && addr_in !== poll_addr) fault_out++;
            poll_set = 1;
            poll_addr = addr_in;
            tog = ~tog;
            rd = {~mem[addr_in][7], tog, mem[addr_in][5:0]};
         end else if (id_mode && addr_in == 17'h0_0000) rd = MAKER_ID;
         else if (id_mode && addr_in == 17'h0_0001) rd = PART_ID;
         else if (id_mode && addr_in == ID_LOCK_LOW_ADDR)
            rd = lock_lo ? 8'hFF : LOCK_FREE_VAL;
         else if (id_mode && addr_in == ID_LOCK_HIGH_ADDR)
            rd = lock_hi ? 8'hFF : LOCK_FREE_VAL;
         else rd = mem[addr_in];
      end
   end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ns
module tb;
   import flash_host_pkg::*;
   logic sys_clk_in = 0;
   logic resetn_in = 0;
   logic clk_en_in = 1;
   logic req_valid_in = 0;
   op_t req_op_in = OP_READ;
   logic [16:0] req_addr_in = '0;
   logic [16:0] flash_addr_out;
   logic [7:0] req_wdata_in = '0;
   logic [7:0] flash_data_in, flash_data_out, resp_data_out, dev_data;
   logic req_ready_out, data_req_out, resp_valid_out, timeout_err_out;
   logic flash_data_oe_n_out, chip_sel_n_out, out_en_n_out, write_n_out;
   int err_total = 0;
   int num_checks = 0;
   int fault, npulse;
   always #4 sys_clk_in = ~sys_clk_in;
   assign flash_data_in = !flash_data_oe_n_out ? flash_data_out : dev_data;

   flash_prog_host #(.BLC_CYCLES(200), .WC_CYCLES(400)) DUT (.sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in), .clk_en_in(clk_en_in), .req_valid_in(req_valid_in),
      .req_op_in(req_op_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
      .pin_data_in(1'b0), .flash_data_in(flash_data_in), .req_ready_out(req_ready_out),
      .data_req_out(data_req_out), .resp_valid_out(resp_valid_out),
      .resp_data_out(resp_data_out), .timeout_err_out(timeout_err_out),
      .flash_addr_out(flash_addr_out), .flash_data_out(flash_data_out),
      .flash_data_oe_n_out(flash_data_oe_n_out), .chip_sel_n_out(chip_sel_n_out),
      .out_en_n_out(out_en_n_out), .write_n_out(write_n_out));

   flash_dev_model #(.MAKER_ID(8'h6C), .PART_ID(8'h93)) partner (.addr_in(flash_addr_out),
      .host_data_in(flash_data_in), .cs_n_in(chip_sel_n_out), .oe_n_in(out_en_n_out),
      .we_n_in(write_n_out), .data_out(dev_data), .fault_out(fault));

   function automatic logic [7:0] pat(input logic [16:0] a);
      return a[7:0] ^ a[15:8];
   endfunction

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // nl loads follow a program request; stops early on a load timeout
   task automatic op(input op_t o, input logic [16:0] a, input logic [7:0] d, input int nl);
      int n;
      int nreq;
      nreq = 0;
      npulse = 0;
      @(negedge sys_clk_in);
      req_valid_in = 1;
      req_op_in = o;
      req_addr_in = a;
      req_wdata_in = d;
      for (n = 0; n < 100 && req_ready_out !== 1'b1; n++) @(posedge sys_clk_in);
      if (n == 100) chk("op accepted", 8'h01, 8'h00);
      @(negedge sys_clk_in);
      req_valid_in = 0;
      for (n = 0; n < 20000; n++) begin
         @(posedge sys_clk_in);
         #1;
         if (resp_valid_out === 1'b1 || timeout_err_out === 1'b1) break;
         if (data_req_out === 1'b1) npulse++;
         if (data_req_out === 1'b1 && nreq < nl) begin
            @(negedge sys_clk_in);
            req_valid_in = 1;
            req_addr_in = 17'(nreq);
            req_wdata_in = d + 8'(nreq);
            nreq++;
            @(negedge sys_clk_in);
            req_valid_in = 0;
         end
      end
      if (n == 20000) chk("op completion", 8'h01, 8'h00);
   endtask

   task automatic rd_chk(input string what, input logic [16:0] a, input logic [7:0] exp);
      op(OP_READ, a, 8'h00, 0);
      chk(what, exp, resp_data_out);
   endtask

   task automatic t_reset();
      chk("idle pins", 8'hF8, {req_ready_out, flash_data_oe_n_out, chip_sel_n_out,
         out_en_n_out, write_n_out, 3'b000});
      rd_chk("array read", 17'h1_2345, pat(17'h1_2345));
      $display("test reset_read done");
   endtask

   // freeze mid-read: strobes must hold, read must still complete
   task automatic t_freeze();
      fork
         rd_chk("read across freeze", 17'h0_0123, pat(17'h0_0123));
         begin
            repeat (10) @(negedge sys_clk_in);
            clk_en_in = 0;
            repeat (40) @(negedge sys_clk_in);
            chk("frozen strobes", 8'h03, {4'h0, chip_sel_n_out, out_en_n_out, write_n_out,
               flash_data_oe_n_out});
            clk_en_in = 1;
         end
      join
      $display("test clock_freeze done");
   endtask

   task automatic t_prog();
      op(OP_PROGRAM, 17'h0_4A80, 8'h30, 128);
      chk("load requests", 8'h80, 8'(npulse));
      chk("timeout flag", 8'h00, {7'b0, timeout_err_out});
      rd_chk("first byte", 17'h0_4A80, 8'h30);
      rd_chk("last byte", 17'h0_4AFF, 8'hAF);
      op(OP_PROGRAM, 17'h1_0100, 8'h70, 128);
      rd_chk("second program", 17'h1_0105, 8'h75);
      $display("test program done");
   endtask

   task automatic t_id();
      op(OP_ID_ENTER, 17'h0_0000, 8'h00, 0);
      rd_chk("maker code", 17'h0_0000, 8'h6C);
      rd_chk("part code", 17'h0_0001, 8'h93);
      rd_chk("low lock free", ID_LOCK_LOW_ADDR, LOCK_FREE_VAL);
      op(OP_LOCK_LOW, 17'h0_0000, 8'h00, 0);
      rd_chk("low lock set", ID_LOCK_LOW_ADDR, 8'hFF);
      rd_chk("high lock free", ID_LOCK_HIGH_ADDR, LOCK_FREE_VAL);
      op(OP_LOCK_HIGH, 17'h0_0000, 8'h00, 0);
      rd_chk("high lock set", ID_LOCK_HIGH_ADDR, 8'hFF);
      op(OP_ID_EXIT, 17'h0_0000, 8'h00, 0);
      rd_chk("array after exit", ID_LOCK_LOW_ADDR, pat(ID_LOCK_LOW_ADDR));
      op(OP_PROGRAM, 17'h0_0000, 8'h00, 128);
      rd_chk("locked block", 17'h0_0005, pat(17'h0_0005));
      $display("test id_lock done");
   endtask

   task automatic t_tmo();
      op(OP_PROGRAM, 17'h0_8000, 8'h10, 3);
      chk("load timeout", 8'h01, {7'b0, timeout_err_out});
      repeat (600) @(posedge sys_clk_in);
      rd_chk("partial load", 17'h0_8001, 8'h11);
      chk("timeout cleared", 8'h00, {7'b0, timeout_err_out});
      chk("bus faults", 8'h00, 8'(fault));
      $display("test load_timeout done");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #800_000;
      err_total++;
      results();
   end

   initial begin
      repeat (5) @(negedge sys_clk_in);
      resetn_in = 1;
      repeat (2) @(negedge sys_clk_in);
      t_reset();
      t_freeze();
      t_prog();
      t_id();
      t_tmo();
      results();
   end
endmodule
